// ---- rtl/gcg_params.svh ----
// constants for the port clock gating block: offsets, fields, reset values
`ifndef GCG_PARAMS_SVH
`define GCG_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define GCG_OFF_RUN_PORT 12'h108
`define GCG_OFF_SLEEP_PORT 12'h118
`define GCG_OFF_DEEP_PORT 12'h128
`define GCG_OFF_RUN_CFG 12'h060
`define GCG_OFF_IRQ_STATUS 12'h200
`define GCG_OFF_IRQ_MASK 12'h204
`define GCG_OFF_POWER_MODE 12'h208

// ****************************************
// fields and reset values
// ****************************************
`define GCG_NUM_PORTS 5
`define GCG_PORT_MSB 4
`define GCG_AUTO_GATE_BIT 27
`define GCG_MODE_MSB 1
`define GCG_PORT_RESET 5'h00
`define GCG_CFG_RESET 32'h0000_0000
`define GCG_IRQ_BITS 2
`define GCG_IRQ_FAULT_BIT 0
`define GCG_IRQ_BADREG_BIT 1

`endif

// ---- rtl/gcg_pkg.sv ----
// types shared by the port clock gating block
package gcg_pkg;
   typedef enum logic [1:0] {
      GCG_MODE_RUN = 2'b00,
      GCG_MODE_SLEEP = 2'b01,
      GCG_MODE_DEEP = 2'b11
   } gcg_mode_e;

   typedef enum logic [1:0] {
      GCG_ST_IDLE = 2'b00,
      GCG_ST_ACK = 2'b01,
      GCG_ST_ERR = 2'b11
   } gcg_bus_e;

   typedef logic [4:0] gcg_ports_t;
endpackage

// ---- rtl/gcg_port_clock_gate.sv ----
// clock enable gating for five general-purpose ports with sleep-mode registers
//
// Functional notes
// R1 - a set gating bit lets that port's clock run so the port works.
// R2 - a clear gating bit stops that port's clock, disabling it to save power.
// R3 - any read or write to a port whose clock is stopped ends with a bus fault.
// R4 - after reset every enable bit of both sleep-mode registers reads zero.
// R5 - software must set the enables of every port it needs, none are set by hardware.
// R6 - in Sleep the port enables come from the sleep-mode gating register.
// R7 - in Deep-Sleep the port enables come from the deep-sleep-mode gating register.
// R8 - the sleep-mode registers act only while the automatic gating bit is set.
// R9 - bits 0 to 4 are ports A to E, bits 31 to 5 are reserved and read zero.
// R10 - the sleep register sits at offset 0x118 and the deep-sleep register at 0x128.
// R11 - with the automatic gating bit clear the run-mode enables rule in every mode.
`timescale 1ns/1ps
`include "gcg_params.svh"

module gcg_port_clock_gate (
   input wire logic clk_sys,
   input wire logic rst,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // system power state from the power manager
   input wire logic [1:0] powerMode,
   // access request aimed at a port, one valid bit and a 3-bit port index
   input wire logic portAccessValid,
   input wire logic [2:0] portAccessSel,
   output logic portAccessFault,
   // per-port clock enables, A in bit 0
   output logic [4:0] portClockEnable,
   output logic irq
);

   // ****************************************
   // helpers
   // ****************************************
   // port field lives in byte lane 0 only
   function automatic logic [4:0] portWrite(input logic [4:0] cur, input logic [31:0] dat,
                                            input logic [3:0] sel);
      portWrite = sel[0] ? dat[`GCG_PORT_MSB:0] : cur;
   endfunction

   function automatic logic [31:0] byteMerge(input logic [31:0] cur, input logic [31:0] dat,
                                             input logic [3:0] sel);
      logic [31:0] res;
      res = cur;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      byteMerge = res;
   endfunction

   // an index past the last port has no clock at all, so it counts as stopped
   function automatic logic portStopped(input logic [4:0] en, input logic [2:0] idx);
      logic stopped;
      stopped = 1'b1;
      for (int i = 0; i < `GCG_NUM_PORTS; i++) begin
         if (idx == i[2:0]) begin
            stopped = ~en[i];
         end
      end
      portStopped = stopped;
   endfunction

   // ****************************************
   // state
   // ****************************************
   gcg_pkg::gcg_ports_t runPort_q;
   gcg_pkg::gcg_ports_t sleepPort_q;
   gcg_pkg::gcg_ports_t deepPort_q;
   logic [31:0] runCfg_q;
   logic [`GCG_IRQ_BITS-1:0] irqStatus_q;
   logic [`GCG_IRQ_BITS-1:0] irqMask_q;
   logic [1:0] mode1_q;
   logic [1:0] mode2_q;
   logic portReq1_q;
   logic portReq2_q;
   logic [2:0] portSel1_q;
   logic [2:0] portSel2_q;
   logic [1:0] mode3_q;
   logic [1:0] modeStable_q;
   logic portReq3_q;
   logic portReqStable_q;
   logic [2:0] portSel3_q;
   logic [2:0] portSelStable_q;
   logic portFault_q;
   logic [31:0] rdData_q;
   gcg_pkg::gcg_bus_e busState_q;
   gcg_pkg::gcg_bus_e busState_d;
   gcg_pkg::gcg_ports_t portEnable_d;
   logic [31:0] rdData_d;
   logic addrKnown;
   logic busReq;
   logic busRd;
   logic busWr;
   logic autoGate;

   assign busReq = wb_cyc_i & wb_stb_i & (busState_q == gcg_pkg::GCG_ST_IDLE);
   assign busWr = busReq & wb_we_i & addrKnown;
   assign busRd = busReq & ~wb_we_i & addrKnown;
   assign autoGate = runCfg_q[`GCG_AUTO_GATE_BIT];

   // ****************************************
   // synchronisers for inputs from other domains
   // ****************************************
   // power mode and port requests come from logic outside this clock
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode1_q <= 2'h0;
         mode2_q <= 2'h0;
         portReq1_q <= 1'b0;
         portReq2_q <= 1'b0;
         portSel1_q <= 3'h0;
         portSel2_q <= 3'h0;
      end else begin
         mode1_q <= powerMode;
         mode2_q <= mode1_q;
         portReq1_q <= portAccessValid;
         portReq2_q <= portReq1_q;
         portSel1_q <= portAccessSel;
         portSel2_q <= portSel1_q;
      end
   end

   // ****************************************
   // word filter behind the synchronisers
   // ****************************************
   // mode and port index are multi-bit words whose bits may land on different edges;
   // a word is passed on only after two equal samples, costing two cycles of latency
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode3_q <= 2'h0;
         modeStable_q <= 2'h0;
         portReq3_q <= 1'b0;
         portReqStable_q <= 1'b0;
         portSel3_q <= 3'h0;
         portSelStable_q <= 3'h0;
      end else begin
         mode3_q <= mode2_q;
         portReq3_q <= portReq2_q;
         portSel3_q <= portSel2_q;
         portReqStable_q <= portReq3_q;
         if (mode2_q == mode3_q) begin
            modeStable_q <= mode3_q;
         end
         if (portSel2_q == portSel3_q) begin
            portSelStable_q <= portSel3_q;
         end
      end
   end

   // ****************************************
   // clock enable selection
   // ****************************************
   always_comb begin
      portEnable_d = runPort_q;
      // R8 gated by auto bit
      // R11 run enables otherwise
      if (autoGate) begin
         case (modeStable_q)
            // R6 sleep register
            gcg_pkg::GCG_MODE_SLEEP: begin
               portEnable_d = sleepPort_q;
            end
            // R7 deep-sleep register
            gcg_pkg::GCG_MODE_DEEP: begin
               portEnable_d = deepPort_q;
            end
            default: begin
               portEnable_d = runPort_q;
            end
         endcase
      end
   end

   // R1 R2 enable drives clocks
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         portClockEnable <= `GCG_PORT_RESET;
      end else begin
         portClockEnable <= portEnable_d;
      end
   end

   // ****************************************
   // fault for stopped ports
   // ****************************************
   // R3 fault on gated port
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         portFault_q <= 1'b0;
      end else begin
         portFault_q <= portReqStable_q & portStopped(portClockEnable, portSelStable_q);
      end
   end
   assign portAccessFault = portFault_q;

   // ****************************************
   // register writes
   // ****************************************
   // R4 all ports reset unclocked
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         runPort_q <= `GCG_PORT_RESET;
         sleepPort_q <= `GCG_PORT_RESET;
         deepPort_q <= `GCG_PORT_RESET;
      end else if (busWr) begin
         // R5 software sets enables
         case (wb_adr_i)
            `GCG_OFF_RUN_PORT: begin
               runPort_q <= portWrite(runPort_q, wb_dat_i, wb_sel_i);
            end
            `GCG_OFF_SLEEP_PORT: begin
               sleepPort_q <= portWrite(sleepPort_q, wb_dat_i, wb_sel_i);
            end
            `GCG_OFF_DEEP_PORT: begin
               deepPort_q <= portWrite(deepPort_q, wb_dat_i, wb_sel_i);
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         runCfg_q <= `GCG_CFG_RESET;
      end else if (busWr && wb_adr_i == `GCG_OFF_RUN_CFG) begin
         runCfg_q <= byteMerge(runCfg_q, wb_dat_i, wb_sel_i);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irqMask_q <= '0;
      end else if (busWr && wb_adr_i == `GCG_OFF_IRQ_MASK && wb_sel_i[0]) begin
         irqMask_q <= wb_dat_i[`GCG_IRQ_BITS-1:0];
      end
   end

   // ****************************************
   // interrupt status
   // ****************************************
   // set wins over the clear-on-read in the same cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irqStatus_q <= '0;
      end else begin
         logic [`GCG_IRQ_BITS-1:0] setBits;
         setBits = '0;
         setBits[`GCG_IRQ_FAULT_BIT] = portFault_q;
         setBits[`GCG_IRQ_BADREG_BIT] = busReq & ~addrKnown;
         if (busRd && wb_adr_i == `GCG_OFF_IRQ_STATUS) begin
            irqStatus_q <= setBits;
         end else begin
            irqStatus_q <= irqStatus_q | setBits;
         end
      end
   end
   assign irq = |(irqStatus_q & irqMask_q);

   // ****************************************
   // read decode
   // ****************************************
   always_comb begin
      rdData_d = 32'h0000_0000;
      addrKnown = 1'b1;
      // R10 register offsets
      // R9 reserved bits read zero
      case (wb_adr_i)
         `GCG_OFF_RUN_PORT: begin
            rdData_d[`GCG_PORT_MSB:0] = runPort_q;
         end
         `GCG_OFF_SLEEP_PORT: begin
            rdData_d[`GCG_PORT_MSB:0] = sleepPort_q;
         end
         `GCG_OFF_DEEP_PORT: begin
            rdData_d[`GCG_PORT_MSB:0] = deepPort_q;
         end
         `GCG_OFF_RUN_CFG: begin
            rdData_d = runCfg_q;
         end
         `GCG_OFF_IRQ_STATUS: begin
            rdData_d[`GCG_IRQ_BITS-1:0] = irqStatus_q;
         end
         `GCG_OFF_IRQ_MASK: begin
            rdData_d[`GCG_IRQ_BITS-1:0] = irqMask_q;
         end
         `GCG_OFF_POWER_MODE: begin
            rdData_d[`GCG_MODE_MSB:0] = modeStable_q;
         end
         default: begin
            addrKnown = 1'b0;
         end
      endcase
   end

   // ****************************************
   // wishbone handshake
   // ****************************************
   // one registered answer per request; the ack/err state blocks back-to-back reuse of the same strobe
   always_comb begin
      busState_d = gcg_pkg::GCG_ST_IDLE;
      case (busState_q)
         gcg_pkg::GCG_ST_IDLE: begin
            if (busReq) begin
               busState_d = addrKnown ? gcg_pkg::GCG_ST_ACK : gcg_pkg::GCG_ST_ERR;
            end
         end
         default: begin
            busState_d = gcg_pkg::GCG_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busState_q <= gcg_pkg::GCG_ST_IDLE;
      end else begin
         busState_q <= busState_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdData_q <= 32'h0000_0000;
      end else if (busRd) begin
         rdData_q <= rdData_d;
      end
   end

   assign wb_ack_o = (busState_q == gcg_pkg::GCG_ST_ACK);
   assign wb_err_o = (busState_q == gcg_pkg::GCG_ST_ERR);
   assign wb_dat_o = rdData_q;

endmodule

// ---- sim/gcg_port_clock_gate_props.sv ----
// concurrent checks on the ports of the port clock gating block
`timescale 1ns/1ps
module gcg_port_clock_gate_props (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic [1:0] powerMode,
   input wire logic portAccessValid,
   input wire logic [2:0] portAccessSel,
   input wire logic portAccessFault,
   input wire logic [4:0] portClockEnable,
   input wire logic irq
);
   // ****
   // checks
   // ****
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_bus_answer_next: assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o || wb_err_o)
      else $error("no answer one cycle after request");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_err_one_pulse: assert property (wb_err_o |=> !wb_err_o)
      else $error("err longer than one cycle");
   a_ack_err_apart: assert property (!(wb_ack_o && wb_err_o))
      else $error("ack and err together");
   a_reserved_read_zero: assert property (wb_ack_o && !wb_we_i && (wb_adr_i == 12'h118 || wb_adr_i == 12'h128)
      |-> wb_dat_o[31:5] == 27'h0)
      else $error("reserved bits read nonzero");
   // the settling window covers the synchroniser and word filter stages
   a_gated_port_fault: assert property ((portAccessValid && portAccessSel < 3'h5
      && !portClockEnable[portAccessSel])[*7] |-> portAccessFault)
      else $error("no fault on access to stopped port");
   a_clocked_port_ok: assert property ((portAccessValid && portAccessSel < 3'h5
      && portClockEnable[portAccessSel])[*7] |-> !portAccessFault)
      else $error("fault on access to clocked port");
   a_reset_all_off: assert property (disable iff (1'b0) rst |=> portClockEnable == 5'h00 && !irq)
      else $error("enables not cleared by reset");
endmodule
bind gcg_port_clock_gate gcg_port_clock_gate_props gcg_port_clock_gate_props_i (
   .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .powerMode(powerMode), .portAccessValid(portAccessValid),
   .portAccessSel(portAccessSel), .portAccessFault(portAccessFault), .portClockEnable(portClockEnable), .irq(irq));

// ---- sim/test_gcg_port_clock_gate.sv ----
// self-checking bench for the port clock gating block
`timescale 1ns/1ps
module test_gcg_port_clock_gate;
   logic clk_sys = 0, rst = 1, cyc = 0, stb = 0, we = 0, pv = 0, ack, err, fault, irq;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0000_0000, rdat, q;
   logic [1:0] mode = 2'b00;
   logic [2:0] psel = 3'h0;
   logic [3:0] sel = 4'hF;
   logic [4:0] en;
   logic e;
   int n_fail = 0, n_tests = 0, cycleCount = 0;
   logic [1:0] modes [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
   logic [4:0] expOn [4] = '{5'h03, 5'h1F, 5'h05, 5'h03};
   gcg_port_clock_gate gcg_port_clock_gate_i (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .wb_err_o(err), .powerMode(mode), .portAccessValid(pv), .portAccessSel(psel), .portAccessFault(fault),
      .portClockEnable(en), .irq(irq));
   initial forever #20 clk_sys = ~clk_sys;
   // ****
   // tasks
   // ****
   task automatic test_done();
      if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_tests++;
      if (g !== x) begin
         n_fail++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   // waits on the answer itself; only the watchdog ends a hang
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_sys);
      cyc <= 1; stb <= 1; adr <= a; we <= w; wdat <= d;
      do @(posedge clk_sys); while (ack !== 1'b1 && err !== 1'b1);
      q = rdat;
      e = err;
      cyc <= 0; stb <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      bus(a, 0, 32'h0);
      chk(q, x);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   always @(posedge clk_sys) begin
      cycleCount++;
      if (cycleCount == 4000) begin
         n_fail++;
         test_done();
      end
   end
   // ****
   // sequence
   // ****
   initial begin
      settle(2);
      rst <= 0;
      rd(12'h118, 32'h0);
      rd(12'h128, 32'h0);
      bus(12'h118, 1, 32'hFFFF_FFFF);
      rd(12'h118, 32'h0000_001F);
      bus(12'h128, 1, 32'h0000_0005);
      rd(12'h128, 32'h0000_0005);
      // the port field sits in byte lane 0, a write without that lane leaves it alone
      sel <= 4'hE;
      bus(12'h128, 1, 32'h0000_0000);
      sel <= 4'hF;
      rd(12'h128, 32'h0000_0005);
      bus(12'h108, 1, 32'h0000_0003);
      for (int g = 0; g < 2; g++) begin
         bus(12'h060, 1, g ? 32'h0800_0000 : 32'h0);
         for (int i = 0; i < 4; i++) begin
            mode <= modes[i];
            settle(8);
            chk({27'h0, en}, {27'h0, g ? expOn[i] : 5'h03});
         end
      end
      rd(12'h060, 32'h0800_0000);
      mode <= 2'b11;
      bus(12'h204, 1, 32'h0000_0001);
      // deep-sleep leaves only ports A and C clocked; index 5 names no port
      for (int p = 0; p < 6; p++) begin
         pv <= 1; psel <= p[2:0];
         settle(8);
         chk({31'h0, fault}, {31'h0, p == 1 || p > 2});
      end
      pv <= 0;
      settle(8);
      chk({31'h0, irq}, 32'h1);
      rd(12'h200, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0);
      bus(12'h300, 0, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rd(12'h208, 32'h0000_0003);
      rd(12'h200, 32'h0000_0002);
      chk({31'h0, irq}, 32'h0);
      test_done();
   end
endmodule
